/* File: rtl/sysclk_mode_controller.v */
// System clock selection, oscillator control and operating mode control.
// Oscillator ticks arrive as one-cycle strobes on clk; oscillator ready
// levels are asynchronous and are synchronised here.
//
// Contract
// RQ1 - Select codes 000 to 110 divide fast clock by 1 to 64; 111 slow.
// RQ2 - Clock control bits 4 to 2 always read as zero.
// RQ3 - Bit 1 keeps fast oscillator running after the stop instruction.
// RQ4 - Bit 0 keeps slow oscillator running after the stop instruction.
// RQ5 - Switch completes after four current periods plus a target edge.
// RQ6 - Enabling the fast oscillator clears stable flag, then sets when stable.
// RQ7 - Fast oscillator enable bit runs the oscillator; resets to one.
// RQ8 - Code 111 moves to slow clock once slow oscillator is stable.
// RQ9 - Codes 000 to 110 return to fast clock once it is stable.
// RQ10 - Stop with both idle bits low enters sleep; CPU holds.
// RQ11 - Sleep turns off all clocks except what the watchdog needs.
// RQ12 - Stop with bits 0 and 1 enters low clock standby.
// RQ13 - Stop with both bits high enters both clock standby.
// RQ14 - Stop with bits 1 and 0 enters high clock standby.
// RQ15 - Halted modes keep memory, registers and port states unchanged.
// RQ16 - Entering a halted mode sets power down, clears timeout flag.
// RQ17 - Entering a halted mode clears watchdog counter; runs if enabled.
// RQ18 - The fast oscillator nominally runs at 8 MHz.
// RQ19 - In sleep the slow oscillator runs only when the watchdog is enabled.
// RQ20 - Halted mode chosen from idle bits in the stop instruction cycle.
// RQ21 - Otherwise CPU runs from selected clock; halts only via stop.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sysclk_regs.vh"

module sysclk_mode_controller #(
    parameter [15:0] WATCHDOG_TOP = `WATCHDOG_TOP
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    input  wire       hfTick,
    input  wire       lfTick,
    input  wire       hfOscReady,
    input  wire       lfOscReady,
    input  wire       stopExec,
    input  wire       wakeReq,
    output reg        hfOscRun,
    output reg        lfOscRun,
    output reg        sysTick,
    output reg        cpuRun,
    output reg        holdState,
    output reg        switchBusy,
    output reg  [2:0] activeSel,
    output reg  [2:0] mode,
    output reg        watchdogReset
);

    // Switch sequencer states
    localparam [1:0] SW_IDLE  = 2'b00;
    localparam [1:0] SW_COUNT = 2'b01;
    localparam [1:0] SW_WAIT  = 2'b10;

    // RQ18 nominal fast period
    localparam integer HF_PERIOD_CYC = `FABRIC_FREQ_HZ / `HF_OSC_FREQ_HZ;
    localparam [7:0] SCC_INIT = `SCC_RESET;
    localparam [7:0] FOC_INIT = `FOC_RESET;
    localparam [7:0] WDC_INIT = `WDC_RESET;

    reg  [2:0]  clkSel;
    reg         hfIdleEn;
    reg         lfIdleEn;
    reg         hfOscEnable;
    reg         hfStableFlag;
    reg         powerDownFlag;
    reg         timeoutFlag;
    reg         watchdogEn;
    reg  [15:0] watchdogCount;
    reg         hfReadyMeta;
    reg         hfReadySync;
    reg         lfReadyMeta;
    reg         lfReadySync;
    reg  [5:0]  divCount;
    reg  [1:0]  swState;
    reg  [2:0]  swCount;
    reg  [7:0]  readValue;
    reg  [2:0]  next_mode;
    reg         next_hfOscRun;
    reg         next_lfOscRun;

    wire        running;
    wire        curTick;
    wire        tarTick;
    wire        tarReady;
    wire        watchdogRun;
    wire        watchdogOvf;
    wire        sccWrite;
    wire        focWrite;
    wire [5:0]  curMask;
    wire [5:0]  tarMask;
    wire        curDivTick;
    wire        tarDivTick;

    assign running = (mode == `MODE_RUN);
    assign sccWrite = wr && (addr == `ADDR_SYS_CLK_CTRL);
    assign focWrite = wr && (addr == `ADDR_FAST_OSC_CTRL);

    // RQ1 divide ratios
    // A divided tick fires when every low counter bit of the ratio is set
    assign curMask = (6'h01 << activeSel) - 6'h01;
    assign tarMask = (6'h01 << clkSel) - 6'h01;
    assign curDivTick = hfTick && (&(divCount | ~curMask));
    assign tarDivTick = hfTick && (&(divCount | ~tarMask));

    assign curTick = (activeSel == `SEL_SLOW) ? lfTick : curDivTick;
    assign tarTick = (clkSel == `SEL_SLOW) ? lfTick : tarDivTick;

    // RQ8 slow target ready
    // RQ9 fast target ready
    assign tarReady = (clkSel == `SEL_SLOW) ? lfReadySync
                                            : (hfReadySync && hfOscRun);

    // RQ17 count when enabled
    assign watchdogRun = watchdogEn && lfOscRun && lfReadySync;
    assign watchdogOvf = watchdogRun && lfTick
                         && (watchdogCount == WATCHDOG_TOP - 16'h0001);

    // Ready levels come from the analogue oscillators
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hfReadyMeta <= 1'b0;
            hfReadySync <= 1'b0;
            lfReadyMeta <= 1'b0;
            lfReadySync <= 1'b0;
        end else if (ce) begin
            hfReadyMeta <= hfOscReady;
            hfReadySync <= hfReadyMeta;
            lfReadyMeta <= lfOscReady;
            lfReadySync <= lfReadyMeta;
        end
    end

    // Fast clock prescaler
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            divCount <= 6'h00;
        end else if (ce && hfTick) begin
            divCount <= divCount + 6'h01;
        end
    end

    // Control registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clkSel      <= SCC_INIT[`SCC_SEL_HI:`SCC_SEL_LO];
            hfIdleEn    <= 1'b0;
            lfIdleEn    <= 1'b0;
            hfOscEnable <= FOC_INIT[`FOC_ENABLE_BIT];
            watchdogEn  <= WDC_INIT[`WDC_ENABLE_BIT];
        end else if (ce) begin
            if (sccWrite) begin
                clkSel   <= wdata[`SCC_SEL_HI:`SCC_SEL_LO];
                hfIdleEn <= wdata[`SCC_HF_IDLE_BIT];
                lfIdleEn <= wdata[`SCC_LF_IDLE_BIT];
            end
            // RQ7 fast oscillator enable
            if (focWrite) begin
                hfOscEnable <= wdata[`FOC_ENABLE_BIT];
            end
            if (wr && (addr == `ADDR_WATCHDOG_CTRL)) begin
                watchdogEn <= wdata[`WDC_ENABLE_BIT];
            end
        end
    end

    // Stable flag follows the synchronised ready level
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hfStableFlag <= 1'b0;
        end else if (ce) begin
            // RQ6 clear on enable
            if (focWrite && wdata[`FOC_ENABLE_BIT] && !hfOscEnable) begin
                hfStableFlag <= 1'b0;
            end else begin
                hfStableFlag <= hfReadySync && hfOscRun;
            end
        end
    end

    // Clock switch sequencer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            swState    <= SW_IDLE;
            swCount    <= 3'h0;
            activeSel  <= SCC_INIT[`SCC_SEL_HI:`SCC_SEL_LO];
            switchBusy <= 1'b0;
        end else if (ce) begin
            case (swState)
                SW_IDLE: begin
                    if (clkSel != activeSel) begin
                        swState    <= SW_COUNT;
                        swCount    <= 3'h0;
                        switchBusy <= 1'b1;
                    end
                end
                // RQ5 four current periods
                SW_COUNT: begin
                    if (clkSel == activeSel) begin
                        swState    <= SW_IDLE;
                        switchBusy <= 1'b0;
                    end else if (running && curTick) begin
                        if (swCount == `SWITCH_CUR_PERIODS - 3'h1) begin
                            swState <= SW_WAIT;
                        end
                        swCount <= swCount + 3'h1;
                    end
                end
                // RQ5 target edge
                SW_WAIT: begin
                    if (clkSel == activeSel) begin
                        swState    <= SW_IDLE;
                        switchBusy <= 1'b0;
                    end else if (tarTick && tarReady) begin
                        // RQ8 commit to slow
                        // RQ9 commit to fast
                        activeSel  <= clkSel;
                        swState    <= SW_IDLE;
                        switchBusy <= 1'b0;
                    end
                end
                default: begin
                    swState    <= SW_IDLE;
                    switchBusy <= 1'b0;
                end
            endcase
        end
    end

    // Mode selection
    always @* begin
        next_mode = mode;
        if (running) begin
            // RQ20 sample idle bits
            // RQ21 halts only on stop
            if (stopExec) begin
                case ({hfIdleEn, lfIdleEn})
                    // RQ10 sleep
                    2'b00: next_mode = `MODE_SLEEP;
                    // RQ12 low clock standby
                    2'b01: next_mode = `MODE_LOW_STANDBY;
                    // RQ14 high clock standby
                    2'b10: next_mode = `MODE_HIGH_STANDBY;
                    // RQ13 both clock standby
                    2'b11: next_mode = `MODE_BOTH_STANDBY;
                    default: next_mode = `MODE_SLEEP;
                endcase
            end
        end else if (wakeReq || watchdogOvf) begin
            next_mode = `MODE_RUN;
        end
    end

    // Oscillator run requests
    always @* begin
        next_hfOscRun = 1'b0;
        next_lfOscRun = 1'b1;
        case (next_mode)
            `MODE_RUN: begin
                next_hfOscRun = hfOscEnable
                                || (activeSel != `SEL_SLOW)
                                || (clkSel != `SEL_SLOW);
                next_lfOscRun = 1'b1;
            end
            // RQ11 sleep clocks off
            // RQ19 watchdog keeps slow
            `MODE_SLEEP: begin
                next_hfOscRun = 1'b0;
                next_lfOscRun = watchdogEn;
            end
            // RQ3 fast idle control
            // RQ4 slow idle control
            `MODE_LOW_STANDBY: begin
                next_hfOscRun = 1'b0;
                next_lfOscRun = 1'b1;
            end
            `MODE_BOTH_STANDBY: begin
                next_hfOscRun = 1'b1;
                next_lfOscRun = 1'b1;
            end
            `MODE_HIGH_STANDBY: begin
                next_hfOscRun = 1'b1;
                next_lfOscRun = watchdogEn;
            end
            default: begin
                next_hfOscRun = 1'b1;
                next_lfOscRun = 1'b1;
            end
        endcase
    end

    // Mode, CPU and clock outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mode      <= `MODE_RUN;
            cpuRun    <= 1'b1;
            holdState <= 1'b0;
            hfOscRun  <= 1'b1;
            lfOscRun  <= 1'b1;
            sysTick   <= 1'b0;
        end else if (ce) begin
            mode     <= next_mode;
            cpuRun   <= (next_mode == `MODE_RUN);
            // RQ15 retain state
            holdState <= (next_mode != `MODE_RUN);
            hfOscRun <= next_hfOscRun;
            lfOscRun <= next_lfOscRun;
            // RQ10 system clock stops
            sysTick  <= running && (next_mode == `MODE_RUN) && curTick;
        end
    end

    // Power status flags
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            powerDownFlag <= 1'b0;
            timeoutFlag   <= 1'b0;
        end else if (ce) begin
            if (running && stopExec) begin
                // RQ16 entry flags
                powerDownFlag <= 1'b1;
                timeoutFlag   <= 1'b0;
            end else begin
                if (wr && (addr == `ADDR_WATCHDOG_CLEAR)) begin
                    powerDownFlag <= 1'b0;
                    timeoutFlag   <= 1'b0;
                end
                if (watchdogOvf) begin
                    timeoutFlag <= 1'b1;
                end
            end
        end
    end

    // Watchdog counter
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdogCount <= 16'h0000;
            watchdogReset <= 1'b0;
        end else if (ce) begin
            watchdogReset <= watchdogOvf && running;
            // RQ17 clear on entry
            if ((running && stopExec) || watchdogOvf
                || (wr && (addr == `ADDR_WATCHDOG_CLEAR))) begin
                watchdogCount <= 16'h0000;
            end else if (watchdogRun && lfTick) begin
                watchdogCount <= watchdogCount + 16'h0001;
            end
        end
    end

    // Register read mux
    always @* begin
        readValue = 8'h00;
        case (addr)
            // RQ2 unused bits zero
            `ADDR_SYS_CLK_CTRL: begin
                readValue[`SCC_SEL_HI:`SCC_SEL_LO] = clkSel;
                readValue[`SCC_HF_IDLE_BIT]        = hfIdleEn;
                readValue[`SCC_LF_IDLE_BIT]        = lfIdleEn;
            end
            `ADDR_FAST_OSC_CTRL: begin
                readValue[`FOC_STABLE_BIT] = hfStableFlag;
                readValue[`FOC_ENABLE_BIT] = hfOscEnable;
            end
            `ADDR_POWER_STATUS: begin
                readValue[`PST_TIMEOUT_BIT]    = timeoutFlag;
                readValue[`PST_POWER_DOWN_BIT] = powerDownFlag;
            end
            `ADDR_WATCHDOG_CTRL: begin
                readValue[`WDC_ENABLE_BIT] = watchdogEn;
            end
            default: begin
                readValue = 8'h00;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? readValue : 8'h00;
        end
    end

endmodule

`default_nettype wire

/* File: common/sysclk_regs.vh */
// Register map, field positions, reset values and timing counts for the
// system clock and operating mode controller.
// Assumes an 8-bit register port and a 100 MHz fabric clock.
`ifndef SYSCLK_REGS_VH
`define SYSCLK_REGS_VH

// Register offsets
`define ADDR_SYS_CLK_CTRL     4'h0
`define ADDR_FAST_OSC_CTRL    4'h1
`define ADDR_POWER_STATUS     4'h2
`define ADDR_WATCHDOG_CTRL    4'h3
`define ADDR_WATCHDOG_CLEAR   4'h4

// system_clock_control fields
`define SCC_SEL_HI            7
`define SCC_SEL_LO            5
`define SCC_HF_IDLE_BIT       1
`define SCC_LF_IDLE_BIT       0
`define SCC_RESET             8'h00
`define SEL_SLOW              3'h7

// fast_oscillator_control fields
`define FOC_STABLE_BIT        1
`define FOC_ENABLE_BIT        0
`define FOC_RESET             8'h01

// power_status fields (read only)
`define PST_TIMEOUT_BIT       1
`define PST_POWER_DOWN_BIT    0

// watchdog_control fields
`define WDC_ENABLE_BIT        0
`define WDC_RESET             8'h01

// Clock switching: current periods counted before the target edge
`define SWITCH_CUR_PERIODS    3'h4
// Fast oscillator frequency, Hz
`define HF_OSC_FREQ_HZ        8000000
// Fabric clock frequency, Hz
`define FABRIC_FREQ_HZ        100000000
// Watchdog overflow count in slow oscillator ticks
`define WATCHDOG_TOP          16'h0100

// Operating modes
`define MODE_RUN              3'h0
`define MODE_SLEEP            3'h1
`define MODE_LOW_STANDBY      3'h2
`define MODE_BOTH_STANDBY     3'h3
`define MODE_HIGH_STANDBY     3'h4

`endif

/* File: bench/sysclk_mode_controller_properties.sv */
// Port-level checks for the system clock and operating mode controller.
// Assumes one clock domain and the offsets and codes of sysclk_regs.vh.
`timescale 1ns/1ns
`default_nettype none
`include "sysclk_regs.vh"
module sysclk_mode_controller_properties #(
    parameter [15:0] WATCHDOG_TOP = `WATCHDOG_TOP
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       hfTick,
    input wire logic       lfTick,
    input wire logic       hfOscReady,
    input wire logic       lfOscReady,
    input wire logic       stopExec,
    input wire logic       wakeReq,
    input wire logic       hfOscRun,
    input wire logic       lfOscRun,
    input wire logic       sysTick,
    input wire logic       cpuRun,
    input wire logic       holdState,
    input wire logic       switchBusy,
    input wire logic [2:0] activeSel,
    input wire logic [2:0] mode,
    input wire logic       watchdogReset
);
    logic [1:0] idleBits;
    logic [2:0] expMode;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Shadow of the idle-enable bits, to predict the halted mode
    always @(posedge clk or posedge rst) begin
        if (rst)
            idleBits <= 2'h0;
        else if (ce && wr && addr == `ADDR_SYS_CLK_CTRL)
            idleBits <= wdata[1:0];
    end
    assign expMode = idleBits == 2'h0 ? `MODE_SLEEP :
                     idleBits == 2'h1 ? `MODE_LOW_STANDBY :
                     idleBits == 2'h2 ? `MODE_HIGH_STANDBY : `MODE_BOTH_STANDBY;

    sequence s_stop_taken;
        ce && stopExec && mode == `MODE_RUN;
    endsequence
    sequence s_halted;
        !cpuRun && holdState && !sysTick;
    endsequence

    a_stop_mode_choice: assert property (s_stop_taken |=>
        mode == $past(expMode) ##0 s_halted) else $error("wrong halted mode");
    a_halt_holds_cpu: assert property (mode != `MODE_RUN |-> s_halted)
        else $error("cpu not held while halted");
    a_halt_only_stop: assert property ($rose(holdState) |->
        $past(stopExec)) else $error("halt without stop instruction");
    a_wake_resumes: assert property (ce && holdState && wakeReq |=>
        mode == `MODE_RUN ##0 cpuRun) else $error("no resume on wake");
    a_halt_fast_osc: assert property (mode != `MODE_RUN |-> hfOscRun ==
        (mode == `MODE_HIGH_STANDBY || mode == `MODE_BOTH_STANDBY))
        else $error("fast oscillator state wrong while halted");
    a_halt_slow_osc: assert property ((mode == `MODE_LOW_STANDBY ||
        mode == `MODE_BOTH_STANDBY) |-> lfOscRun)
        else $error("slow oscillator off in standby");
    a_sel_at_end: assert property (!$stable(activeSel) |->
        $past(switchBusy) && !switchBusy) else $error("select moved early");
    a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    a_ctrl_gap_zero: assert property (rd && addr == `ADDR_SYS_CLK_CTRL |=>
        rdata[4:2] == 3'h0) else $error("unused control bits nonzero");
endmodule
bind sysclk_mode_controller sysclk_mode_controller_properties #(
    .WATCHDOG_TOP(WATCHDOG_TOP)
) props (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .hfTick(hfTick), .lfTick(lfTick),
    .hfOscReady(hfOscReady), .lfOscReady(lfOscReady),
    .stopExec(stopExec), .wakeReq(wakeReq), .hfOscRun(hfOscRun),
    .lfOscRun(lfOscRun), .sysTick(sysTick), .cpuRun(cpuRun),
    .holdState(holdState), .switchBusy(switchBusy),
    .activeSel(activeSel), .mode(mode), .watchdogReset(watchdogReset)
);
`default_nettype wire

/* File: bench/sysclk_mode_controller_tb.sv */
// Self-checking bench for the system clock and mode controller.
// Models the oscillators itself and drives the register port directly.
`timescale 1ns/1ns
`default_nettype none
`include "sysclk_regs.vh"
module sysclk_mode_controller_tb;
    localparam int wdTop = 16;
    logic       clk, rst, ce, wr, rd, hfTick, lfTick, stopExec, wakeReq;
    logic       hfOscReady, lfOscReady, hfOscRun, lfOscRun, sysTick;
    logic       cpuRun, holdState, switchBusy, watchdogReset;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] activeSel, mode;
    int         mismatches, n_checks, cyc;

    sysclk_mode_controller #(.WATCHDOG_TOP(16'h0010)) DUT (
        .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .hfTick(hfTick), .lfTick(lfTick),
        .hfOscReady(hfOscReady), .lfOscReady(lfOscReady),
        .stopExec(stopExec), .wakeReq(wakeReq), .hfOscRun(hfOscRun),
        .lfOscRun(lfOscRun), .sysTick(sysTick), .cpuRun(cpuRun),
        .holdState(holdState), .switchBusy(switchBusy),
        .activeSel(activeSel), .mode(mode), .watchdogReset(watchdogReset)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Fast ticks every 3 cycles, slow every 7, ready one cycle after run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        hfTick <= hfOscRun && (cyc % 3 == 0);
        lfTick <= lfOscRun && (cyc % 7 == 0);
        hfOscReady <= hfOscRun;
        lfOscReady <= lfOscRun;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd_reg(a, v);
        chk(v, exp);
    endtask

    task automatic pulse(input bit stop);
        @(posedge clk);
        if (stop) stopExec <= 1'b1;
        else wakeReq <= 1'b1;
        @(posedge clk);
        stopExec <= 1'b0;
        wakeReq <= 1'b0;
        #1;
    endtask

    task automatic wait_until(input bit onTick, input logic [2:0] s);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (onTick && sysTick === 1'b1) break;
            if (!onTick && activeSel === s && switchBusy === 1'b0) break;
        end
    endtask

    task automatic test_reset;
        repeat (5) @(posedge clk);
        rd_chk(`ADDR_SYS_CLK_CTRL, `SCC_RESET);
        rd_chk(`ADDR_FAST_OSC_CTRL, 8'h03);
        rd_chk(`ADDR_POWER_STATUS, 8'h00);
        rd_chk(`ADDR_WATCHDOG_CTRL, `WDC_RESET);
        rd_chk(4'hF, 8'h00);
        wr_reg(`ADDR_WATCHDOG_CTRL, 8'h00);
        chk({4'h0, cpuRun, activeSel}, 8'h08);
        wr_reg(`ADDR_SYS_CLK_CTRL, 8'h1F);
        rd_chk(`ADDR_SYS_CLK_CTRL, 8'h03);
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(`ADDR_SYS_CLK_CTRL, 8'hE0);
        ce <= 1'b1;
        rd_chk(`ADDR_SYS_CLK_CTRL, 8'h03);
        #1;
        chk({4'h0, switchBusy, activeSel}, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_select;
        int t0, g, cur, tar;
        logic [2:0] s;
        cur = 3;
        for (int k = 1; k <= 8; k++) begin
            s = k[2:0];
            tar = (s == `SEL_SLOW) ? 7 : 3 << s;
            wr_reg(`ADDR_SYS_CLK_CTRL, {s, 5'h00});
            t0 = cyc;
            wait_until(1'b0, s);
            chk({5'h00, activeSel}, {5'h00, s});
            chk({7'h00, cyc - t0 <= 6 * cur + 2 * tar + 8}, 8'h01);
            wait_until(1'b1, s);
            t0 = cyc;
            wait_until(1'b1, s);
            g = cyc - t0;
            chk(g[7:0], tar[7:0]);
            cur = tar;
        end
        $display("test select done");
    endtask

    task automatic test_slow_return;
        logic [7:0] v;
        wr_reg(`ADDR_SYS_CLK_CTRL, 8'hE0);
        wait_until(1'b0, `SEL_SLOW);
        wr_reg(`ADDR_FAST_OSC_CTRL, 8'h00);
        repeat (6) @(posedge clk);
        chk({7'h00, hfOscRun}, 8'h00);
        rd_chk(`ADDR_FAST_OSC_CTRL, 8'h00);
        wr_reg(`ADDR_FAST_OSC_CTRL, 8'h01);
        rd_chk(`ADDR_FAST_OSC_CTRL, 8'h01);
        for (int i = 0; i < 20; i++) begin
            rd_reg(`ADDR_FAST_OSC_CTRL, v);
            if (v === 8'h03) break;
        end
        chk(v, 8'h03);
        wr_reg(`ADDR_SYS_CLK_CTRL, 8'h00);
        wait_until(1'b0, 3'h0);
        chk({5'h00, activeSel}, 8'h00);
        $display("test slow return done");
    endtask

    task automatic test_modes;
        logic [2:0] em [4] = '{`MODE_SLEEP, `MODE_LOW_STANDBY,
                               `MODE_HIGH_STANDBY, `MODE_BOTH_STANDBY};
        for (int b = 0; b < 4; b++) begin
            wr_reg(`ADDR_WATCHDOG_CLEAR, 8'h00);
            wr_reg(`ADDR_SYS_CLK_CTRL, {6'h00, b[1:0]});
            pulse(1'b1);
            chk({5'h00, mode}, {5'h00, em[b]});
            chk({6'h00, hfOscRun, lfOscRun}, {6'h00, b[1:0]});
            repeat (20) @(posedge clk);
            chk({5'h00, cpuRun, holdState, sysTick}, 8'h02);
            rd_chk(`ADDR_POWER_STATUS, 8'h01);
            rd_chk(`ADDR_SYS_CLK_CTRL, {6'h00, b[1:0]});
            pulse(1'b0);
            chk({4'h0, cpuRun, mode}, 8'h08);
        end
        $display("test modes done");
    endtask

    task automatic test_watchdog;
        int i;
        wr_reg(`ADDR_WATCHDOG_CTRL, 8'h01);
        wr_reg(`ADDR_WATCHDOG_CLEAR, 8'h00);
        wr_reg(`ADDR_SYS_CLK_CTRL, 8'h00);
        repeat (wdTop * 7 / 2) @(posedge clk);
        pulse(1'b1);
        chk({6'h00, hfOscRun, lfOscRun}, 8'h01);
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (mode === `MODE_RUN) break;
        end
        chk({7'h00, i >= wdTop * 7 - 12 && i < wdTop * 7 + 20}, 8'h01);
        rd_chk(`ADDR_POWER_STATUS, 8'h03);
        pulse(1'b1);
        rd_chk(`ADDR_POWER_STATUS, 8'h01);
        pulse(1'b0);
        wr_reg(`ADDR_WATCHDOG_CLEAR, 8'h00);
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (watchdogReset === 1'b1) break;
        end
        chk({7'h00, i >= wdTop * 7 - 12 && i < wdTop * 7 + 20}, 8'h01);
        rd_chk(`ADDR_POWER_STATUS, 8'h02);
        wr_reg(`ADDR_WATCHDOG_CTRL, 8'h00);
        $display("test watchdog done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        mismatches++;
        tally_and_finish;
    end

    initial begin
        {rst, ce, wr, rd, stopExec, wakeReq} = 6'h30;
        {hfTick, lfTick, hfOscReady, lfOscReady} = 4'h0;
        addr = 4'h0;
        wdata = 8'h00;
        cyc = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_reset;
        test_select;
        test_slow_return;
        test_modes;
        test_watchdog;
        tally_and_finish;
    end
endmodule
`default_nettype wire
